// File: rtl/sld_cfg_if.sv
// interface carrying latched strap codes to the decoder
`timescale 1ns/1ps
interface sld_cfg_if;
   logic [5:0]          dis_pos;
   logic [5:0]          dis_neg;
   sld_pkg::sld_level_t fixed_lvl;
   sld_pkg::sld_level_t chg_lvl;
   logic [2:0]          mode_lvl_2;
   logic [2:0]          mode_lvl_1;
   logic [5:0]          port_off;
   logic [2:0]          fixed_cnt;
   logic [2:0]          chg_cnt;
   logic                mode_ok;
   modport src (output dis_pos, dis_neg, fixed_lvl, chg_lvl, mode_lvl_2,
                mode_lvl_1, input port_off, fixed_cnt, chg_cnt, mode_ok);
   modport dec (input dis_pos, dis_neg, fixed_lvl, chg_lvl, mode_lvl_2,
                mode_lvl_1, output port_off, fixed_cnt, chg_cnt, mode_ok);
endinterface

// File: rtl/sld_decode.sv
// combinational decode of latched strap codes
`timescale 1ns/1ps
`include "sld_defs.svh"
module sld_decode (
   sld_cfg_if.dec cfg   // latched codes in, decoded values out
);
   import sld_pkg::*;

   // level code to count of ports, reserved codes give zero
   function automatic logic [2:0] lvl_to_cnt(input sld_level_t l);
      case (l)
         `SLD_LVL_200K_PD: lvl_to_cnt = 3'h0;
         `SLD_LVL_200K_PU: lvl_to_cnt = 3'h1;
         `SLD_LVL_10K_PD:  lvl_to_cnt = 3'h2;
         `SLD_LVL_10K_PU:  lvl_to_cnt = 3'h3;
         `SLD_LVL_10R_PD:  lvl_to_cnt = 3'h4;
         `SLD_LVL_10R_PU:  lvl_to_cnt = 3'h6;
         default:          lvl_to_cnt = 3'h0;
      endcase
   endfunction

   // port off only with both lines high; covers usb2 and usb3 halves
   assign cfg.port_off  = cfg.dis_pos & cfg.dis_neg;
   assign cfg.fixed_cnt = lvl_to_cnt(cfg.fixed_lvl);
   assign cfg.chg_cnt   = lvl_to_cnt(cfg.chg_lvl);
   // single valid mode, every other pairing reserved
   assign cfg.mode_ok   = (cfg.mode_lvl_2 == `SLD_LVL_200K_PD) &&
                          (cfg.mode_lvl_1 == `SLD_LVL_10K_PD);
endmodule

// File: rtl/sld_defs.svh
// constants for the strap latch decoder
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH
`define SLD_NPORTS        6
`define SLD_LVL_200K_PD   3'h0
`define SLD_LVL_200K_PU   3'h1
`define SLD_LVL_10K_PD    3'h2
`define SLD_LVL_10K_PU    3'h3
`define SLD_LVL_10R_PD    3'h4
`define SLD_LVL_10R_PU    3'h5
`define SLD_ADR_CTRL      4'h0
`define SLD_ADR_PORTS     4'h4
`define SLD_ADR_COUNTS    4'h8
`define SLD_ADR_MODE      4'hC
`define SLD_CTRL_RESET    1'h0
`define SLD_LATCH_TIME_NS 10
`define SLD_LATCH_CYC     ((`SLD_LATCH_TIME_NS + 4) / 5)
`endif

// File: rtl/sld_pkg.sv
// types for the strap latch decoder
package sld_pkg;
   typedef enum logic [1:0] {
      SLD_ST_RESET = 2'b00,
      SLD_ST_LATCH = 2'b01,
      SLD_ST_RUN   = 2'b10
   } sld_state_t;
   typedef logic [2:0] sld_level_t;
endpackage

// File: rtl/sld_top.sv
// strap latch decoder: capture straps at reset release, decode, wishbone
`timescale 1ns/1ps
`include "sld_defs.svh"
module sld_top #(
   parameter int NPORTS = `SLD_NPORTS   // downstream port count
) (
   input  wire logic                clk_i,       // 200 MHz clock
   input  wire logic                rst_i,       // power-on reset, high
   input  wire logic                ext_rst_n_i, // external reset, low
   input  wire logic [NPORTS-1:0]   port_pos_line_disable_strap_i, // d+ strap
   input  wire logic [NPORTS-1:0]   port_neg_line_disable_strap_i, // d- strap
   input  wire sld_pkg::sld_level_t fixed_port_count_strap_i,    // level
   input  wire sld_pkg::sld_level_t charging_port_count_strap_i, // level
   input  wire sld_pkg::sld_level_t mode_strap_3_i, // mode strap 3 level
   input  wire sld_pkg::sld_level_t mode_strap_2_i, // mode strap 2 level
   input  wire sld_pkg::sld_level_t mode_strap_1_i, // mode strap 1 level
   input  wire logic                wb_cyc_i,    // wishbone cycle
   input  wire logic                wb_stb_i,    // wishbone strobe
   input  wire logic                wb_we_i,     // write enable
   input  wire logic [3:0]          wb_adr_i,    // byte address
   input  wire logic [3:0]          wb_sel_i,    // byte selects
   input  wire logic [31:0]         wb_dat_i,    // write data
   output logic [31:0]              wb_dat_o,    // read data
   output logic                     wb_ack_o,    // acknowledge
   output logic [NPORTS-1:0]        port_disable_o, // usb2 and usb3 off
   output logic [2:0]               fixed_port_cnt_o, // non-removable ports
   output logic [2:0]               charging_port_cnt_o, // bc1.2 ports
   output logic                     mode_valid_o, // mode straps valid
   output logic                     cfg_ready_o   // configuration captured
);
   import sld_pkg::*;

   sld_cfg_if  cfg ();
   sld_state_t state_reg;
   logic [3:0] cnt_reg;
   logic       ext_rst_n_d_reg;
   logic       relatch_reg;
   logic       capture;
   logic [5:0] dis_pos_reg;
   logic [5:0] dis_neg_reg;
   sld_level_t fixed_reg;
   sld_level_t chg_reg;
   sld_level_t mode3_reg;
   sld_level_t mode2_reg;
   sld_level_t mode1_reg;
   logic       wb_req;

   // previous external reset level, for release edge
   // resets low on purpose: power-on then reads as a release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_rst_n_d_reg <= 1'b0;
      end else begin
         ext_rst_n_d_reg <= ext_rst_n_i;
      end
   end

   // software relatch request, self clearing after the capture
   // the write lands on the edge where the master sees ack high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         relatch_reg <= `SLD_CTRL_RESET;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_ack_o &&
                   wb_adr_i == `SLD_ADR_CTRL) begin
         relatch_reg <= wb_dat_i[0];
      end else if (capture) begin
         relatch_reg <= 1'b0;
      end
   end

   // sequencer: hold in reset, wait settle count, capture once, run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= SLD_ST_RESET;
         cnt_reg   <= 4'h0;
      end else begin
         case (state_reg)
            SLD_ST_RESET: begin
               cnt_reg <= 4'h0;
               if (ext_rst_n_i) begin
                  state_reg <= SLD_ST_LATCH;
               end
            end
            SLD_ST_LATCH: begin
               if (!ext_rst_n_i) begin
                  state_reg <= SLD_ST_RESET;
               end else if (cnt_reg == 4'(`SLD_LATCH_CYC - 1)) begin
                  state_reg <= SLD_ST_RUN;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            SLD_ST_RUN: begin
               if (!ext_rst_n_i || relatch_reg) begin
                  state_reg <= SLD_ST_RESET;
               end
            end
            default: state_reg <= SLD_ST_RESET;
         endcase
      end
   end

   // capture at the end of the latch window only; pins free afterwards
   assign capture = (state_reg == SLD_ST_LATCH) && ext_rst_n_i &&
                    (cnt_reg == 4'(`SLD_LATCH_CYC - 1));

   // strap holding registers, sampled together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dis_pos_reg <= 6'h00;
         dis_neg_reg <= 6'h00;
         fixed_reg   <= `SLD_LVL_200K_PD;
         chg_reg     <= `SLD_LVL_200K_PD;
         mode3_reg   <= `SLD_LVL_200K_PD;
         mode2_reg   <= `SLD_LVL_200K_PD;
         mode1_reg   <= `SLD_LVL_200K_PD;
      end else if (capture) begin
         dis_pos_reg <= 6'(port_pos_line_disable_strap_i);
         dis_neg_reg <= 6'(port_neg_line_disable_strap_i);
         fixed_reg   <= fixed_port_count_strap_i;
         chg_reg     <= charging_port_count_strap_i;
         mode3_reg   <= mode_strap_3_i;
         mode2_reg   <= mode_strap_2_i;
         mode1_reg   <= mode_strap_1_i;
      end
   end

   assign cfg.dis_pos    = dis_pos_reg;
   assign cfg.dis_neg    = dis_neg_reg;
   assign cfg.fixed_lvl  = fixed_reg;
   assign cfg.chg_lvl    = chg_reg;
   assign cfg.mode_lvl_2 = mode2_reg;
   assign cfg.mode_lvl_1 = mode1_reg;

   sld_decode u_dec (
      .cfg (cfg)
   );

   // registered decoded outputs, ready only while running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_disable_o      <= '0;
         fixed_port_cnt_o    <= 3'h0;
         charging_port_cnt_o <= 3'h0;
         mode_valid_o        <= 1'b0;
         cfg_ready_o         <= 1'b0;
      end else begin
         port_disable_o      <= NPORTS'(cfg.port_off);
         fixed_port_cnt_o    <= cfg.fixed_cnt;
         charging_port_cnt_o <= cfg.chg_cnt;
         mode_valid_o        <= cfg.mode_ok;
         cfg_ready_o         <= (state_reg == SLD_ST_RUN);
      end
   end

   // wishbone slave, one wait state; ack drops after one cycle
   assign wb_req = wb_cyc_i && wb_stb_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
         if (wb_req && !wb_ack_o) begin
            if (wb_adr_i == `SLD_ADR_CTRL) begin
               wb_dat_o <= {29'h0, state_reg, relatch_reg};
            end else if (wb_adr_i == `SLD_ADR_PORTS) begin
               wb_dat_o <= {8'h00, 2'h0, cfg.port_off, 2'h0, dis_neg_reg,
                            2'h0, dis_pos_reg};
            end else if (wb_adr_i == `SLD_ADR_COUNTS) begin
               wb_dat_o <= {13'h0, chg_reg, 5'h0, fixed_reg, 1'h0,
                            cfg.chg_cnt, 1'h0, cfg.fixed_cnt};
            end else if (wb_adr_i == `SLD_ADR_MODE) begin
               wb_dat_o <= {19'h0, cfg.mode_ok, 1'h0, mode3_reg, 1'h0,
                            mode2_reg, 1'h0, mode1_reg};
            end else begin
               wb_dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   // assertions
   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
         (state_reg == SLD_ST_RUN) |=> $stable(fixed_reg) && $stable(chg_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("strap code moved");
   property p_dis;
      @(posedge clk_i) disable iff (rst_i)
         ##1 port_disable_o == NPORTS'($past(dis_pos_reg & dis_neg_reg));
   endproperty
   a_dis: assert property (p_dis) else $error("port disable wrong");
   property p_cnt;
      @(posedge clk_i) disable iff (rst_i)
         $past(fixed_reg) == `SLD_LVL_10R_PU |-> fixed_port_cnt_o == 3'h6;
   endproperty
   a_cnt: assert property (p_cnt) else $error("fixed count wrong");
   property p_chg;
      @(posedge clk_i) disable iff (rst_i)
         $past(chg_reg) == `SLD_LVL_200K_PD |-> charging_port_cnt_o == 3'h0;
   endproperty
   a_chg: assert property (p_chg) else $error("charge count wrong");
   property p_mode;
      @(posedge clk_i) disable iff (rst_i)
         mode_valid_o |-> $past(mode2_reg) == `SLD_LVL_200K_PD &&
                          $past(mode1_reg) == `SLD_LVL_10K_PD;
   endproperty
   a_mode: assert property (p_mode) else $error("mode valid wrong");
   property p_rel;
      @(posedge clk_i) disable iff (rst_i)
         ext_rst_n_i && !ext_rst_n_d_reg && state_reg == SLD_ST_RESET
            |-> ##[1:4] capture;
   endproperty
   a_rel: assert property (p_rel) else $error("no capture on release");
   property p_cap;
      @(posedge clk_i) disable iff (rst_i)
         capture |=> fixed_reg == $past(fixed_port_count_strap_i);
   endproperty
   a_cap: assert property (p_cap) else $error("strap not latched");
   property p_pos;
      @(posedge clk_i) disable iff (rst_i)
         capture |=> dis_pos_reg == 6'($past(port_pos_line_disable_strap_i));
   endproperty
   a_pos: assert property (p_pos) else $error("line strap lost");
   c_cap: cover property (@(posedge clk_i) capture);
   c_off: cover property (@(posedge clk_i) port_disable_o != '0);
   c_ok:  cover property (@(posedge clk_i) mode_valid_o);
endmodule

// File: tb/sld_board_model.sv
// board side model: strap resistor levels, then other pin traffic
`timescale 1ns/1ps
module sld_board_model (
   input  wire logic                clk_i,  // device clock
   input  wire logic                hold_i, // present settled levels
   input  wire logic [5:0]          pos_i,  // wanted d+ straps
   input  wire logic [5:0]          neg_i,  // wanted d- straps
   input  wire sld_pkg::sld_level_t fix_i,  // wanted fixed level
   input  wire sld_pkg::sld_level_t chg_i,  // wanted charging level
   input  wire sld_pkg::sld_level_t m2_i,   // wanted mode 2 level
   input  wire sld_pkg::sld_level_t m1_i,   // wanted mode 1 level
   output sld_pkg::sld_level_t      m3_o,   // mode strap 3 pin
   output logic [5:0]               pos_o,  // d+ pins
   output logic [5:0]               neg_o,  // d- pins
   output sld_pkg::sld_level_t      fix_o,  // fixed port pin
   output sld_pkg::sld_level_t      chg_o,  // charging pin
   output sld_pkg::sld_level_t      m2_o,   // mode 2 pin
   output sld_pkg::sld_level_t      m1_o    // mode 1 pin
);
   import sld_pkg::*;
   logic [7:0] traffic_reg = 8'h3C; // later pin functions
   // unused strap parked at 200k pull-down
   assign m3_o = 3'h0;
   // moves every cycle so a stale capture cannot look right
   always_ff @(posedge clk_i) begin
      traffic_reg <= traffic_reg + 8'h5B;
   end
   // settled levels while held, foreign traffic otherwise
   always_ff @(posedge clk_i) begin
      if (hold_i) begin
         pos_o <= pos_i;
         neg_o <= neg_i;
         fix_o <= fix_i;
         chg_o <= chg_i;
         m2_o <= m2_i;
         m1_o <= m1_i;
      end else begin
         pos_o <= traffic_reg[5:0];
         neg_o <= ~traffic_reg[7:2];
         fix_o <= traffic_reg[2:0];
         chg_o <= traffic_reg[7:5];
         m2_o <= ~traffic_reg[3:1];
         m1_o <= traffic_reg[4:2];
      end
   end
endmodule

// File: tb/testbench.sv
// self-checking bench for the strap latch decoder
`timescale 1ns/1ps
module testbench;
   import sld_pkg::*;
   logic       clk, rst, ext_n, hold, cyc, stb, we, ack, ok_o, rdy;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, dat_o;
   logic [5:0] pos, neg, pos_w, neg_w, off_o;
   logic [2:0] fcnt_o, ccnt_o;
   sld_level_t fix, chg, m2, m1, fix_w, chg_w, m3_w, m2_w, m1_w;
   integer     seed;
   int         err_total, comparisons, it;
   sld_board_model sld_board_model_inst (.clk_i(clk), .hold_i(hold),
      .pos_i(pos), .neg_i(neg), .fix_i(fix), .chg_i(chg), .m2_i(m2),
      .m1_i(m1), .m3_o(m3_w), .pos_o(pos_w), .neg_o(neg_w), .fix_o(fix_w),
      .chg_o(chg_w), .m2_o(m2_w), .m1_o(m1_w));
   sld_top #(.NPORTS(6)) sld_top_inst (.clk_i(clk), .rst_i(rst),
      .ext_rst_n_i(ext_n), .port_pos_line_disable_strap_i(pos_w),
      .port_neg_line_disable_strap_i(neg_w),
      .fixed_port_count_strap_i(fix_w), .charging_port_count_strap_i(chg_w),
      .mode_strap_3_i(m3_w), .mode_strap_2_i(m2_w), .mode_strap_1_i(m1_w),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .port_disable_o(off_o), .fixed_port_cnt_o(fcnt_o),
      .charging_port_cnt_o(ccnt_o), .mode_valid_o(ok_o), .cfg_ready_o(rdy));
   // level code to port count, reserved codes count none
   function automatic logic [2:0] cnt(input logic [2:0] l);
      return (l == 3'h5) ? 3'h6 : (l > 3'h5) ? 3'h0 : l;
   endfunction
   // compare and count
   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // no cycle limit here: a lost ack is left to the watchdog
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // ack is due one edge after the request is taken
      chk("wb_ack_delay", 32'h2, 32'(n));
   endtask
   // waits up to 8 cycles for ready to drop for the capture, then checks it comes back
   task automatic wait_ready();
      int n;
      n = 0;
      while (rdy !== 1'b0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("cfg_ready", 32'h1, 32'(rdy));
   endtask
   task automatic check_all();
      logic [5:0]  off;
      logic        ok;
      logic [31:0] e;
      off = pos & neg;
      ok = (m2 == 3'h0) && (m1 == 3'h2);
      chk("port_disable", 32'(off), 32'(off_o));
      chk("fixed_cnt", 32'(cnt(fix)), 32'(fcnt_o));
      chk("charging_cnt", 32'(cnt(chg)), 32'(ccnt_o));
      chk("mode_valid", 32'(ok), 32'(ok_o));
      wb(1'b1, 4'h4, $random(seed));
      wb(1'b0, 4'h4, 32'h0);
      chk("ports_reg", {10'h0, off, 2'h0, neg, 2'h0, pos}, rdat);
      wb(1'b0, 4'h8, 32'h0);
      e = {13'h0, chg, 5'h0, fix, 1'h0, cnt(chg), 1'h0, cnt(fix)};
      chk("counts_reg", e, rdat);
      wb(1'b0, 4'hC, 32'h0);
      chk("mode_reg", {19'h0, ok, 5'h0, m2, 1'h0, m1}, rdat);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rdat);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard, far beyond the expected run
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   // capture by external reset, relatch and power-on reset in turn
   initial begin
      seed = 32'hA2A5;
      {rst, hold, ext_n, cyc, stb, we, adr, wdat} = {3'h7, 39'h0};
      {pos, neg, fix, chg, m2, m1} = {21'h0, 3'h2};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_ready();
      for (it = 0; it < 12; it++) begin
         @(posedge clk);
         pos <= (it == 3 || it == 4) ? 6'h3F : 6'($random(seed));
         neg <= (it == 3) ? 6'h3F : (it == 4) ? 6'h00 : 6'($random(seed));
         fix <= (it < 6) ? 3'(it) : 3'($random(seed));
         chg <= (it < 6) ? 3'(5 - it) : 3'($random(seed));
         m2 <= it[0] ? 3'($random(seed)) : 3'h0;
         m1 <= it[0] ? 3'($random(seed)) : 3'h2;
         hold <= 1'b1;
         repeat (3) @(posedge clk);
         if (it % 3 == 0) begin
            ext_n <= 1'b0;
            repeat (3) @(posedge clk);
            ext_n <= 1'b1;
         end else if (it % 3 == 1) begin
            wb(1'b1, 4'h0, 32'h1);
         end else begin
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
         end
         wait_ready();
         hold <= 1'b0;
         repeat (5) @(posedge clk);
         check_all();
      end
      end_of_test();
   end
endmodule
